// ==== core/thr_regs.svh ====
// Purpose: register offsets, masks and reset values for the port threshold block
// Assumes: 16-bit register words on the documented register port
// Notes: Function list of the block follows
// Function
// [RL1] main register low-byte bits select CMOS levels
// [RL2] extended register bits 5,3,1 select high bytes
// [RL3] extended register bits 4,2,0 select low bytes
// [RL4] port 9 register gives each line a select
// [RL5] set register write sets bits written one
// [RL6] clear register write clears bits written one
// [RL7] port 10 register gives each line a select
// [RL8] each line has one alternate function
// [RL9] alternate output needs direction one, else high-z
// [RL10] pin drives latch AND alternate output, except PWM
// [RL11] software sets input direction for driven pins
// [RL12] every line is input after reset
// [RL13] output-direction line feeds latch to alternate input
// [RL14] hardware switches direction for auto-direction functions
// [RL15] software sets direction before enabling alternate function
// [RL16] software writes latch before enabling drivers
// [RL17] unassigned lines stay general purpose I/O
// [RL18] software separates bit-set pairs on one port
// [RL19] pin level sampled into input latch each state
// [RL20] extension registers need both enable bits set
// [RL21] reserved bits ignore writes, read zero
`ifndef THR_REGS_SVH
`define THR_REGS_SVH

`define MAIN_THR_OFFSET 16'hf1c4
`define EXT_THR_OFFSET 16'hf1c6
`define P9_THR_OFFSET 16'heb98
`define P9_SET_OFFSET 16'heb9a
`define P9_CLR_OFFSET 16'heb9c
`define P10_THR_OFFSET 16'hebd8

`define MAIN_THR_MASK 16'h00ff
`define EXT_THR_MASK 16'h003f
`define EXT_HIGH_MASK 16'h002a
`define EXT_LOW_MASK 16'h0015

`define MAIN_THR_RESET 16'h0000
`define EXT_THR_RESET 16'h0000
`define P9_THR_RESET 16'h0000
`define P10_THR_RESET 16'h0000

`endif

// ==== core/thr_pkg.sv ====
// Purpose: shared types of the port threshold block
// Assumes: nothing beyond the register header
// Notes: register words are 16 bits wide
package thr_pkg;
    typedef logic [15:0] word_type;
    typedef enum logic [2:0] {
        SEL_NONE,
        SEL_MAIN,
        SEL_EXT,
        SEL_P9,
        SEL_P9_SET,
        SEL_P9_CLR,
        SEL_P10
    } reg_sel_type;
endpackage

// ==== core/line_if.sv ====
// Purpose: carries one port's line controls between the top and the line logic
// Assumes: one bit per line in every vector
// Notes: the top drives the control side, the line logic answers
`timescale 1ns/1ps
`default_nettype none
interface line_if #(parameter int LINES = 16);
    logic [LINES-1:0] dir;      // software direction bits
    logic [LINES-1:0] latch;    // port output latch
    logic [LINES-1:0] alt_en;   // alternate function enabled
    logic [LINES-1:0] alt_out;  // alternate output data
    logic [LINES-1:0] alt_pwm;  // alternate output is a pwm signal
    logic [LINES-1:0] auto_dir; // hardware owns direction
    logic [LINES-1:0] hw_dir;   // hardware direction request
    logic [LINES-1:0] pin_in;   // pad level
    logic [LINES-1:0] pin_out;  // pad output data
    logic [LINES-1:0] pin_oe;   // pad output enable
    logic [LINES-1:0] alt_in;   // alternate input data
    logic [LINES-1:0] in_latch; // sampled pad level
    modport ctrl (output dir, latch, alt_en, alt_out, alt_pwm, auto_dir, hw_dir, pin_in,
                  input pin_out, pin_oe, alt_in, in_latch);
    modport line (input dir, latch, alt_en, alt_out, alt_pwm, auto_dir, hw_dir, pin_in,
                  output pin_out, pin_oe, alt_in, in_latch);
endinterface
`default_nettype wire

// ==== core/line_logic.sv ====
// Purpose: per-line direction, output and alternate input combining
// Assumes: pad inputs are synchronous to the clock
// Notes: open-drain and per-port data registers live outside
`timescale 1ns/1ps
`default_nettype none
module line_logic #(
    parameter int LINES = 16
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic arst_n_i,
    // line group
    line_if.line lines
);
    import thr_pkg::*;

    logic [LINES-1:0] pin_out_ff, nxt_pin_out; // registered pad data
    logic [LINES-1:0] oe_ff, nxt_oe;           // registered pad enable
    logic [LINES-1:0] in_latch_ff, nxt_in;     // sampled pad level
    logic [LINES-1:0] latch_ff, nxt_latch;     // latch copy for alternate input

    // output data, enable and sampling next values
    always_comb begin
        // plain lines pass the latch; non-pwm alternate outputs are gated by it, pwm outputs xor with it
        nxt_pin_out = (~lines.alt_en & lines.latch) //  [RL17]
            | (lines.alt_en & ~lines.alt_pwm & lines.alt_out & lines.latch) // [RL10]
            | (lines.alt_en & lines.alt_pwm & (lines.alt_out ^ lines.latch)); // [RL8]
        // auto-direction functions override software direction
        nxt_oe = (lines.auto_dir & lines.alt_en & lines.hw_dir) // [RL14]
            | (~(lines.auto_dir & lines.alt_en) & lines.dir); // [RL9]
        nxt_in = lines.pin_in; // [RL19]
        nxt_latch = lines.latch;
    end

    // registers; reset leaves every line an input
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pin_out_ff <= '0;
            oe_ff <= '0; // [RL12]
            in_latch_ff <= '0;
            latch_ff <= '0;
        end else begin
            pin_out_ff <= nxt_pin_out;
            oe_ff <= nxt_oe;
            in_latch_ff <= nxt_in;
            latch_ff <= nxt_latch;
        end
    end

    assign lines.pin_out = pin_out_ff;
    assign lines.pin_oe = oe_ff;
    assign lines.in_latch = in_latch_ff;
    // driving lines loop the latch back so software can trigger the input
    assign lines.alt_in = (oe_ff & latch_ff) | (~oe_ff & in_latch_ff); // [RL13]

    and_gate_a: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [RL10]
        1'b1 |=> ((pin_out_ff & $past(lines.alt_en & ~lines.alt_pwm))
            == ($past(lines.alt_out & lines.latch & lines.alt_en & ~lines.alt_pwm))))
        else $error("alternate output not gated by latch");
    dir_follow_a: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [RL9]
        1'b1 |=> ((oe_ff & ~$past(lines.auto_dir & lines.alt_en))
            == ($past(lines.dir & ~(lines.auto_dir & lines.alt_en)))))
        else $error("pad enable does not follow direction");
    auto_dir_a: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [RL14]
        1'b1 |=> ((oe_ff & $past(lines.auto_dir & lines.alt_en))
            == $past(lines.hw_dir & lines.auto_dir & lines.alt_en)))
        else $error("hardware direction not applied");
    loop_back_a: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [RL13]
        1'b1 |=> ((lines.alt_in & oe_ff) == ($past(lines.latch) & oe_ff)))
        else $error("output line does not feed latch to alternate input");
    sample_pin_a: assert property (@(posedge clk_i) disable iff (!arst_n_i) // [RL19]
        1'b1 |=> (in_latch_ff == $past(lines.pin_in)))
        else $error("pad level not sampled");
endmodule
`default_nettype wire

// ==== core/port_threshold.sv ====
// Purpose: input threshold registers and line control for the port group
// Assumes: single register access per cycle, pins synchronous to MCLK_I
// Notes: read data appears one cycle after the read strobe
`timescale 1ns/1ps
`default_nettype none
`include "thr_regs.svh"
module port_threshold #(
    parameter int LINES = 16
) (
    // clock and reset
    input wire logic MCLK_I,
    input wire logic ARST_N_I,
    // register port
    input wire thr_pkg::word_type REG_ADDR_I,
    input wire logic REG_WR_I,
    input wire logic REG_RD_I,
    input wire thr_pkg::word_type REG_WDATA_I,
    output thr_pkg::word_type REG_RDATA_O,
    // extension peripheral enables from the two configuration registers
    input wire logic SYSTEM_CONFIG_EXT_PERIPHERAL_ENABLE_I,
    input wire logic EXT_PERIPHERAL_CONFIG_ENABLE_I,
    // threshold selects toward the pads
    output logic [7:0] LOW_BYTE_CMOS_SELECT_O,
    output logic [2:0] EXT_LOW_BYTE_CMOS_SELECT_O,
    output logic [2:0] HIGH_BYTE_CMOS_SELECT_O,
    output thr_pkg::word_type EXT9_LINE_CMOS_SELECT_O,
    output thr_pkg::word_type EXT10_LINE_CMOS_SELECT_O,
    // line controls
    input wire logic [LINES-1:0] LINE_DIRECTION_BIT_I,
    input wire logic [LINES-1:0] LINE_LATCH_I,
    input wire logic [LINES-1:0] ALT_EN_I,
    input wire logic [LINES-1:0] ALT_OUT_I,
    input wire logic [LINES-1:0] ALT_PWM_I,
    input wire logic [LINES-1:0] AUTO_DIR_I,
    input wire logic [LINES-1:0] HW_DIR_I,
    // pads
    input wire logic [LINES-1:0] PIN_IN_I,
    output logic [LINES-1:0] PIN_OUT_O,
    output logic [LINES-1:0] PIN_OE_O,
    output logic [LINES-1:0] ALT_IN_O,
    output logic [LINES-1:0] IN_LATCH_O
);
    import thr_pkg::*;

    word_type main_thr_ff, nxt_main_thr; // main threshold select
    word_type ext_thr_ff, nxt_ext_thr;   // extended threshold select
    word_type p9_thr_ff, nxt_p9_thr;     // port 9 per-line select
    word_type p10_thr_ff, nxt_p10_thr;   // port 10 per-line select
    word_type rdata_ff, nxt_rdata;       // registered read data
    reg_sel_type wr_sel;                 // decoded write target
    reg_sel_type rd_sel;                 // decoded read target
    logic ext_ok;                        // extension registers visible


    // extension registers exist only with both enables set
    assign ext_ok = SYSTEM_CONFIG_EXT_PERIPHERAL_ENABLE_I
        & EXT_PERIPHERAL_CONFIG_ENABLE_I; // [RL20]

    // address decode shared by reads and writes
    function automatic reg_sel_type decode(input word_type addr, input logic ext_vis);
        reg_sel_type sel;
        sel = SEL_NONE;
        unique case (addr)
            `MAIN_THR_OFFSET: sel = SEL_MAIN;
            `EXT_THR_OFFSET: sel = SEL_EXT;
            `P9_THR_OFFSET: sel = ext_vis ? SEL_P9 : SEL_NONE; // [RL20]
            `P9_SET_OFFSET: sel = ext_vis ? SEL_P9_SET : SEL_NONE;
            `P9_CLR_OFFSET: sel = ext_vis ? SEL_P9_CLR : SEL_NONE;
            `P10_THR_OFFSET: sel = ext_vis ? SEL_P10 : SEL_NONE;
            default: sel = SEL_NONE; // unmapped address
        endcase
        return sel;
    endfunction

    assign wr_sel = REG_WR_I ? decode(REG_ADDR_I, ext_ok) : SEL_NONE;
    assign rd_sel = REG_RD_I ? decode(REG_ADDR_I, ext_ok) : SEL_NONE;


    // register writes
    always_comb begin
        nxt_main_thr = main_thr_ff;
        nxt_ext_thr = ext_thr_ff;
        nxt_p9_thr = p9_thr_ff;
        nxt_p10_thr = p10_thr_ff;
        unique case (wr_sel)
            SEL_NONE: begin
                // nothing written
            end
            SEL_MAIN: begin
                // only the upper byte is reserved; bits 7..0 are low-byte selects
                nxt_main_thr = REG_WDATA_I & `MAIN_THR_MASK; // [RL1] [RL21]
            end
            SEL_EXT: begin
                // high and low byte selects interleave in bits 5..0
                nxt_ext_thr = REG_WDATA_I & `EXT_THR_MASK; // [RL2] [RL3] [RL21]
            end
            SEL_P9: begin
                nxt_p9_thr = REG_WDATA_I; // [RL4]
            end
            SEL_P9_SET: begin
                // atomic set avoids a read-modify-write race
                nxt_p9_thr = p9_thr_ff | REG_WDATA_I; // [RL5]
            end
            SEL_P9_CLR: begin
                // zero bits leave the select untouched
                nxt_p9_thr = p9_thr_ff & ~REG_WDATA_I; // [RL6]
            end
            SEL_P10: begin
                nxt_p10_thr = REG_WDATA_I; // [RL7]
            end
        endcase
    end

    always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            main_thr_ff <= `MAIN_THR_RESET;
            ext_thr_ff <= `EXT_THR_RESET;
            p9_thr_ff <= `P9_THR_RESET;
            p10_thr_ff <= `P10_THR_RESET;
        end else begin
            main_thr_ff <= nxt_main_thr;
            ext_thr_ff <= nxt_ext_thr;
            p9_thr_ff <= nxt_p9_thr;
            p10_thr_ff <= nxt_p10_thr;
        end
    end

    // read data; write-only registers and holes read zero
    always_comb begin
        nxt_rdata = rdata_ff;
        if (REG_RD_I) begin
            unique case (rd_sel)
                SEL_MAIN: nxt_rdata = main_thr_ff; // [RL21]
                SEL_EXT: nxt_rdata = ext_thr_ff;
                SEL_P9: nxt_rdata = p9_thr_ff;
                SEL_P10: nxt_rdata = p10_thr_ff;
                SEL_NONE, SEL_P9_SET, SEL_P9_CLR: nxt_rdata = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            rdata_ff <= 16'h0000;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign REG_RDATA_O = rdata_ff;

    // threshold selects, 0 for ttl and 1 for cmos
    assign LOW_BYTE_CMOS_SELECT_O = main_thr_ff[7:0]; // [RL1]
    assign HIGH_BYTE_CMOS_SELECT_O = {ext_thr_ff[5], ext_thr_ff[3], ext_thr_ff[1]}; // [RL2]
    assign EXT_LOW_BYTE_CMOS_SELECT_O = {ext_thr_ff[4], ext_thr_ff[2], ext_thr_ff[0]}; // [RL3]
    assign EXT9_LINE_CMOS_SELECT_O = p9_thr_ff; // [RL4]
    assign EXT10_LINE_CMOS_SELECT_O = p10_thr_ff; // [RL7]

    // line control group
    line_if #(.LINES(LINES)) lines ();

    assign lines.dir = LINE_DIRECTION_BIT_I;
    assign lines.latch = LINE_LATCH_I;
    assign lines.alt_en = ALT_EN_I;
    assign lines.alt_out = ALT_OUT_I;
    assign lines.alt_pwm = ALT_PWM_I;
    assign lines.auto_dir = AUTO_DIR_I;
    assign lines.hw_dir = HW_DIR_I;
    assign lines.pin_in = PIN_IN_I;

    assign PIN_OUT_O = lines.pin_out;
    assign PIN_OE_O = lines.pin_oe;
    assign ALT_IN_O = lines.alt_in;
    assign IN_LATCH_O = lines.in_latch;

    line_logic #(.LINES(LINES)) u_lines (
        .clk_i(MCLK_I),
        .arst_n_i(ARST_N_I),
        .lines(lines)
    );

    // checks on the register side
    sequence s_set_write;
        REG_WR_I && ext_ok && (REG_ADDR_I == `P9_SET_OFFSET);
    endsequence

    sequence s_clr_write;
        REG_WR_I && ext_ok && (REG_ADDR_I == `P9_CLR_OFFSET);
    endsequence

    sequence s_blocked_write;
        REG_WR_I && !ext_ok && ((REG_ADDR_I == `P9_THR_OFFSET)
            || (REG_ADDR_I == `P9_SET_OFFSET) || (REG_ADDR_I == `P9_CLR_OFFSET)
            || (REG_ADDR_I == `P10_THR_OFFSET));
    endsequence

    set_bits_a: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I) // [RL5]
        s_set_write |=> (p9_thr_ff == ($past(p9_thr_ff) | $past(REG_WDATA_I))))
        else $error("set register did not set written ones");

    clr_bits_a: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I) // [RL6]
        s_clr_write |=> (p9_thr_ff == ($past(p9_thr_ff) & ~$past(REG_WDATA_I))))
        else $error("clear register did not clear written ones");

    // every writable main bit lands one cycle after its strobe
    main_write_a: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I) // [RL1]
        (REG_WR_I && (REG_ADDR_I == `MAIN_THR_OFFSET))
        |=> (LOW_BYTE_CMOS_SELECT_O == $past(REG_WDATA_I[7:0])))
        else $error("main threshold write lost");

    ext_high_a: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I) // [RL2]
        (REG_WR_I && (REG_ADDR_I == `EXT_THR_OFFSET))
        |=> (HIGH_BYTE_CMOS_SELECT_O == {$past(REG_WDATA_I[5]), $past(REG_WDATA_I[3]),
            $past(REG_WDATA_I[1])}))
        else $error("high byte select wrong");

    ext_low_a: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I) // [RL3]
        (REG_WR_I && (REG_ADDR_I == `EXT_THR_OFFSET))
        |=> (EXT_LOW_BYTE_CMOS_SELECT_O == {$past(REG_WDATA_I[4]), $past(REG_WDATA_I[2]),
            $past(REG_WDATA_I[0])}))
        else $error("low byte select wrong");

    p9_write_a: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I) // [RL4]
        (REG_WR_I && ext_ok && (REG_ADDR_I == `P9_THR_OFFSET))
        |=> (EXT9_LINE_CMOS_SELECT_O == $past(REG_WDATA_I)))
        else $error("port 9 select write lost");

    p10_write_a: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I) // [RL7]
        (REG_WR_I && ext_ok && (REG_ADDR_I == `P10_THR_OFFSET))
        |=> (EXT10_LINE_CMOS_SELECT_O == $past(REG_WDATA_I)))
        else $error("port 10 select write lost");

    ext_gate_a: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I) // [RL20]
        s_blocked_write |=> ($stable(p9_thr_ff) && $stable(p10_thr_ff)))
        else $error("extension register written while hidden");

    // read side: the upper byte of the main register reads zero
    reserved_zero_a: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I) // [RL21]
        (REG_RD_I && (REG_ADDR_I == `MAIN_THR_OFFSET))
        |=> (REG_RDATA_O == {8'h00, $past(main_thr_ff[7:0])}))
        else $error("reserved bits read nonzero");

    reset_input_a: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I) // [RL12]
        $rose(ARST_N_I) |-> (PIN_OE_O == '0))
        else $error("line driving right after reset");

    // hidden extension registers answer a read with zeros
    sequence s_hidden_read;
        REG_RD_I && !ext_ok && ((REG_ADDR_I == `P9_THR_OFFSET)
            || (REG_ADDR_I == `P10_THR_OFFSET));
    endsequence

    // set and clear strobes have no storage behind them
    sequence s_strobe_read;
        REG_RD_I && ((REG_ADDR_I == `P9_SET_OFFSET) || (REG_ADDR_I == `P9_CLR_OFFSET));
    endsequence

    hidden_read_a: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I) // [RL20]
        s_hidden_read |=> (REG_RDATA_O == 16'h0000))
        else $error("hidden extension register read nonzero");

    strobe_read_a: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I) // [RL6]
        s_strobe_read |=> (REG_RDATA_O == 16'h0000))
        else $error("set or clear register read nonzero");

    // reserved upper bits of the extended register read zero
    ext_reserved_a: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I) // [RL21]
        (REG_RD_I && (REG_ADDR_I == `EXT_THR_OFFSET))
        |=> (REG_RDATA_O == {10'h000, $past(ext_thr_ff[5:0])}))
        else $error("extended register reads back wrong");

    p9_read_a: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I) // [RL4]
        (REG_RD_I && ext_ok && (REG_ADDR_I == `P9_THR_OFFSET))
        |=> (REG_RDATA_O == $past(p9_thr_ff)))
        else $error("port 9 select reads back wrong");

    p10_read_a: assert property (@(posedge MCLK_I) disable iff (!ARST_N_I) // [RL7]
        (REG_RD_I && ext_ok && (REG_ADDR_I == `P10_THR_OFFSET))
        |=> (REG_RDATA_O == $past(p10_thr_ff)))
        else $error("port 10 select reads back wrong");
endmodule
`default_nettype wire

// ==== bench/ext_device.sv ====
// Purpose: far-side device model on the pads of the port lines
// Assumes: pads sampled by the block on the rising clock edge
// Notes: an undriven line shows the inverse of its last level, not a fixed value
`timescale 1ns/1ps
`default_nettype none
module ext_device #(
    parameter int LINES = 16
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic arst_n_i,
    // block side of the pads
    input wire logic [LINES-1:0] pin_out_i,
    input wire logic [LINES-1:0] pin_oe_i,
    // far-side drive request per line
    input wire logic [LINES-1:0] drive_i,
    input wire logic [LINES-1:0] value_i,
    // resolved pad level
    output logic [LINES-1:0] pad_o
);
    logic [LINES-1:0] last_ff; // last pad level, seeds the floating pattern
    // remember the pad so a floating line never repeats its old value
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            last_ff <= '0;
        end else begin
            last_ff <= pad_o;
        end
    end
    // the block wins where it drives; the far side drives only input lines
    always_comb begin
        pad_o = (pin_oe_i & pin_out_i) | (~pin_oe_i & drive_i & value_i)
            | (~pin_oe_i & ~drive_i & ~last_ff);
    end
endmodule
`default_nettype wire

// ==== bench/tb_port_threshold.sv ====
// Purpose: self-checking bench for the port threshold block
// Assumes: strobe register port, 4 ns clock, xorshift stimulus seeded at 19
// Notes: expectations come from bench functions, never from the outputs
`timescale 1ns/1ps
`default_nettype none
`include "thr_regs.svh"
module tb_port_threshold;
    import thr_pkg::*;
    localparam int LINES = 16;
    localparam int CEILING = 20000; // the tests need about 670 cycles
    logic mclk;
    logic arst_n;
    logic wr_s, rd_s, sys_en, xper_en;
    word_type reg_addr, reg_wdata, reg_rdata, ext9_sel, ext10_sel, v, p9_exp, p10_exp;
    logic [7:0] low_sel;
    logic [2:0] ext_low_sel, high_sel;
    logic [LINES-1:0] dir, latch, alt_en, alt_out, alt_pwm, auto_dir, hw_dir;
    logic [LINES-1:0] pad, pin_out, pin_oe, alt_in, in_latch, ext_val, ext_drv;
    int err_total = 0;
    int checks_done = 0;
    int cycles = 0;
    logic [31:0] seed = 32'h13;
    // free-running clock
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    port_threshold #(.LINES(LINES)) port_threshold_inst (
        .MCLK_I(mclk), .ARST_N_I(arst_n), .REG_ADDR_I(reg_addr), .REG_WR_I(wr_s),
        .REG_RD_I(rd_s), .REG_WDATA_I(reg_wdata), .REG_RDATA_O(reg_rdata),
        .SYSTEM_CONFIG_EXT_PERIPHERAL_ENABLE_I(sys_en), .EXT_PERIPHERAL_CONFIG_ENABLE_I(xper_en),
        .LOW_BYTE_CMOS_SELECT_O(low_sel), .EXT_LOW_BYTE_CMOS_SELECT_O(ext_low_sel),
        .HIGH_BYTE_CMOS_SELECT_O(high_sel), .EXT9_LINE_CMOS_SELECT_O(ext9_sel),
        .EXT10_LINE_CMOS_SELECT_O(ext10_sel), .LINE_DIRECTION_BIT_I(dir),
        .LINE_LATCH_I(latch), .ALT_EN_I(alt_en), .ALT_OUT_I(alt_out), .ALT_PWM_I(alt_pwm),
        .AUTO_DIR_I(auto_dir), .HW_DIR_I(hw_dir), .PIN_IN_I(pad), .PIN_OUT_O(pin_out),
        .PIN_OE_O(pin_oe), .ALT_IN_O(alt_in), .IN_LATCH_O(in_latch));
    ext_device #(.LINES(LINES)) ext_device_inst (
        .clk_i(mclk), .arst_n_i(arst_n), .pin_out_i(pin_out), .pin_oe_i(pin_oe),
        .drive_i(ext_drv), .value_i(ext_val), .pad_o(pad));
    // xorshift source, fixed seed keeps runs repeatable
    function automatic word_type rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[15:0];
    endfunction
    // expected pad data: latch gates the alternate output, pwm xors with it
    function automatic word_type exp_out(input word_type e, p, a, l);
        return (~e & l) | (e & ~p & a & l) | (e & p & (a ^ l));
    endfunction
    // expected enable: hardware direction only when it owns an enabled line
    function automatic word_type exp_oe(input word_type au, e, h, d);
        return (au & e & h) | (~(au & e) & d);
    endfunction
    task automatic cmp_reg(input word_type got, input word_type exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t register got %h want %h", $time, got, exp);
        end
    endtask
    task automatic cmp_line(input word_type got, input word_type exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t lines got %h want %h", $time, got, exp);
        end
    endtask
    // one write, then an idle edge so the strobe is never re-raised at once
    task automatic write_reg(input word_type a, input word_type d);
        reg_addr = a;
        reg_wdata = d;
        wr_s = 1'b1;
        @(posedge mclk);
        #1;
        wr_s = 1'b0;
        @(posedge mclk);
        #1;
    endtask
    task automatic check_rd(input word_type a, input word_type exp);
        reg_addr = a;
        rd_s = 1'b1;
        @(posedge mclk);
        #1;
        rd_s = 1'b0;
        cmp_reg(reg_rdata, exp);
        @(posedge mclk);
        #1;
    endtask
    // drive one set of line controls and check the registered answer
    task automatic line_step(input word_type e, p, a, l, d, au, h);
        word_type pad_s, oe_x;
        latch = l;
        dir = d;
        alt_en = e;
        alt_pwm = p;
        alt_out = a;
        auto_dir = au;
        hw_dir = h;
        ext_val = rnd();
        ext_drv = rnd();
        #1;
        pad_s = pad;
        @(posedge mclk);
        #1;
        oe_x = exp_oe(au, e, h, d);
        cmp_line(pin_out, exp_out(e, p, a, l));
        cmp_line(pin_oe, oe_x);
        cmp_line(in_latch, pad_s);
        cmp_line(alt_in, (oe_x & l) | (~oe_x & pad_s));
    endtask
    task automatic end_test(input string name);
        $display("test %s done at %0t", name, $time);
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // hang guard
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == CEILING) begin
            err_total++;
            $display("MISMATCH t=%0t run did not finish", $time);
            summarize();
        end
    end
    initial begin
        {arst_n, wr_s, rd_s, reg_addr, reg_wdata} = '0;
        {sys_en, xper_en} = 2'b11;
        {dir, latch, alt_en, alt_out, alt_pwm, auto_dir, hw_dir, ext_val} = '0;
        ext_drv = '1;
        repeat (12) @(posedge mclk);
        #1;
        cmp_line(pin_oe, '0);
        arst_n = 1'b1;
        @(posedge mclk);
        #1;
        check_rd(`MAIN_THR_OFFSET, `MAIN_THR_RESET);
        check_rd(`EXT_THR_OFFSET, `EXT_THR_RESET);
        check_rd(`P9_THR_OFFSET, `P9_THR_RESET);
        check_rd(`P10_THR_OFFSET, `P10_THR_RESET);
        end_test("reset");
        repeat (20) begin
            v = rnd();
            write_reg(`MAIN_THR_OFFSET, v);
            cmp_reg({8'h00, low_sel}, v & `MAIN_THR_MASK);
            check_rd(`MAIN_THR_OFFSET, v & `MAIN_THR_MASK);
            write_reg(`EXT_THR_OFFSET, v);
            cmp_reg({13'h0000, high_sel}, {13'h0000, v[5], v[3], v[1]});
            cmp_reg({13'h0000, ext_low_sel}, {13'h0000, v[4], v[2], v[0]});
            check_rd(`EXT_THR_OFFSET, v & `EXT_THR_MASK);
            p10_exp = v;
            write_reg(`P10_THR_OFFSET, v);
            cmp_reg(ext10_sel, v);
            check_rd(`P10_THR_OFFSET, v);
            p9_exp = rnd();
            write_reg(`P9_THR_OFFSET, p9_exp);
            v = rnd();
            write_reg(`P9_SET_OFFSET, v);
            p9_exp = p9_exp | v;
            cmp_reg(ext9_sel, p9_exp);
            v = rnd();
            write_reg(`P9_CLR_OFFSET, v);
            p9_exp = p9_exp & ~v;
            cmp_reg(ext9_sel, p9_exp);
            check_rd(`P9_THR_OFFSET, p9_exp);
        end
        write_reg(`P9_CLR_OFFSET, 16'h0000);
        cmp_reg(ext9_sel, p9_exp);
        check_rd(`P9_CLR_OFFSET, 16'h0000);
        check_rd(`P9_SET_OFFSET, 16'h0000);
        write_reg(16'heb9e, 16'hffff);
        cmp_reg(ext9_sel, p9_exp);
        check_rd(16'heb9e, 16'h0000);
        end_test("registers");
        for (int k = 0; k < 3; k++) begin
            {sys_en, xper_en} = k[1:0];
            write_reg(`P9_SET_OFFSET, ~p9_exp);
            write_reg(`P10_THR_OFFSET, ~p10_exp);
            cmp_reg(ext9_sel, p9_exp);
            cmp_reg(ext10_sel, p10_exp);
            check_rd(`P9_THR_OFFSET, 16'h0000);
            check_rd(`P10_THR_OFFSET, 16'h0000);
        end
        {sys_en, xper_en} = 2'b11;
        check_rd(`P9_THR_OFFSET, p9_exp);
        end_test("enables");
        line_step('1, '0, '1, '1, '1, '0, '0);
        line_step('1, '0, '1, '0, '1, '0, '0);
        line_step('1, '1, '1, '1, '1, '0, '0);
        line_step('1, '0, '1, '1, '0, '1, '1);
        line_step('1, '0, '1, '1, '1, '1, '0);
        line_step('0, '1, '1, 16'h5a5a, '1, '1, '0);
        line_step('1, '0, '0, '1, '0, '0, '1);
        repeat (200) begin
            line_step(rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), rnd());
        end
        end_test("lines");
        arst_n = 1'b0;
        @(posedge mclk);
        #1;
        cmp_line(pin_oe, '0);
        cmp_reg(ext9_sel, `P9_THR_RESET);
        arst_n = 1'b1;
        @(posedge mclk);
        #1;
        cmp_line(pin_oe, exp_oe(auto_dir, alt_en, hw_dir, dir));
        check_rd(`P9_THR_OFFSET, `P9_THR_RESET);
        end_test("second reset");
        summarize();
    end
endmodule
`default_nettype wire
